// ### core/bcce_core.sv
`timescale 1ns/1ps
`default_nettype none
`include "bcce_defines.svh"
module bcce_core
  import bcce_pkg::*;
(
  input wire logic MCLK_IN,
  input wire logic RST_IN,
  input wire logic [15:0] INSTR_IN,
  input wire logic [7:0] MEM_RDATA_IN,
  output logic [15:0] PC_OUT,
  output logic INSTR_FETCH_OUT,
  output logic [7:0] MEM_ADDR_OUT,
  output logic MEM_WE_OUT,
  output logic [7:0] MEM_WDATA_OUT,
  output logic STACK_PUSH_OUT,
  output logic [15:0] STACK_DATA_OUT,
  output logic WDT_CLEAR_OUT,
  output logic [7:0] COUNTER_LATCH_HIGH_OUT,
  output logic [7:0] WORKING_REGISTER_OUT,
  output logic [7:0] ARITH_STATUS_REGISTER_OUT
);

  bcce_state_type s_reg;
  bcce_state_type s_next;

  logic [15:0] op;
  logic [7:0] w;
  logic [8:0] diff;
  logic is_bitinv;
  logic is_call;
  logic is_zero;
  logic is_wdt;
  logic is_comp;
  logic is_skeq;
  logic is_skgt;

  assign op = s_reg.ir;
  assign w = s_reg.working_register;
  assign is_bitinv = (op[15:11] == `BCCE_OP_BITINV);
  assign is_call = (op[15:13] == `BCCE_OP_CALL);
  assign is_zero = (op[15:9] == `BCCE_OP_ZERO);
  assign is_wdt = (op == `BCCE_OP_WDTCLR);
  assign is_comp = (op[15:9] == `BCCE_OP_COMP);
  assign is_skeq = (op[15:8] == `BCCE_OP_SKEQ);
  assign is_skgt = (op[15:8] == `BCCE_OP_SKGT);
  // difference never leaves this block
  assign diff = {1'b0, s_reg.opnd} - {1'b0, w};

  always_comb begin
    s_next = s_reg;
    s_next.mem_wr.we = 1'b0;
    s_next.push.push = 1'b0;
    s_next.wdt_clr = 1'b0;
    s_next.fetch = 1'b0;
    unique case (s_reg.phase)
      BCCE_Q1: begin
        s_next.phase = BCCE_Q2;
        s_next.mem_wr.addr = op[7:0];
      end
      BCCE_Q2: begin
        s_next.phase = BCCE_Q3;
        s_next.opnd = MEM_RDATA_IN;
      end
      BCCE_Q3: begin
        s_next.phase = BCCE_Q4;
        s_next.res_to_reg = 1'b0;
        s_next.res_to_w = 1'b0;
        s_next.result = 8'h00;
        if (!s_reg.forced_nop) begin
          if (is_bitinv) begin
            s_next.result = s_reg.opnd ^ (8'h01 << op[10:8]);
            s_next.res_to_reg = 1'b1;
          end else if (is_call) begin
            s_next.push.push = 1'b1;
            // counter already stepped past the call when it was fetched
            s_next.push.addr = s_reg.pc;
            s_next.latch_high = {s_reg.pc[15:13], op[12:8]};
            s_next.pc = {s_reg.pc[15:13], op[12:0]};
            s_next.skip_pend = 1'b1;
          end else if (is_zero) begin
            s_next.res_to_reg = 1'b1;
            s_next.res_to_w = !op[8];
          end else if (is_wdt) begin
            s_next.wdt_clr = 1'b1;
            s_next.status[`BCCE_ST_TO_BIT] = 1'b1;
            s_next.status[`BCCE_ST_PD_BIT] = 1'b1;
          end else if (is_comp) begin
            s_next.result = ~s_reg.opnd;
            s_next.res_to_reg = op[8];
            s_next.res_to_w = !op[8];
            s_next.status[`BCCE_ST_Z_BIT] = (s_reg.opnd == 8'hFF);
          end else if (is_skeq) begin
            s_next.skip_pend = (diff == 9'h000);
          end else if (is_skgt) begin
            // no borrow and nonzero means register above working
            s_next.skip_pend = !diff[8] && (diff[7:0] != 8'h00);
          end
        end
      end
      BCCE_Q4: begin
        s_next.phase = BCCE_Q1;
        if (s_reg.res_to_reg) begin
          s_next.mem_wr.we = 1'b1;
          s_next.mem_wr.wdata = s_reg.result;
        end
        if (s_reg.res_to_w) begin
          s_next.working_register = s_reg.result;
        end
        s_next.res_to_reg = 1'b0;
        s_next.res_to_w = 1'b0;
        // fetched word dropped and run as nop when a skip is pending
        s_next.forced_nop = s_reg.skip_pend;
        s_next.skip_pend = 1'b0;
        s_next.ir = INSTR_IN;
        s_next.fetch = 1'b1;
        if (!(s_reg.forced_nop == 1'b0 && is_call)) begin
          s_next.pc = s_reg.pc + 16'h0001;
        end
      end
    endcase
  end

  always_ff @(posedge MCLK_IN) begin
    if (RST_IN) begin
      s_reg <= '0;
      s_reg.phase <= BCCE_Q1;
      s_reg.pc <= `BCCE_PC_RST;
      s_reg.working_register <= `BCCE_WORKING_REGISTER_RST;
      s_reg.latch_high <= `BCCE_LATCH_RST;
      s_reg.status <= `BCCE_STATUS_RST;
      s_reg.forced_nop <= 1'b1;
    end else begin
      s_reg <= s_next;
    end
  end

  assign PC_OUT = s_reg.pc;
  assign INSTR_FETCH_OUT = s_reg.fetch;
  assign MEM_ADDR_OUT = s_reg.mem_wr.addr;
  assign MEM_WE_OUT = s_reg.mem_wr.we;
  assign MEM_WDATA_OUT = s_reg.mem_wr.wdata;
  assign STACK_PUSH_OUT = s_reg.push.push;
  assign STACK_DATA_OUT = s_reg.push.addr;
  assign WDT_CLEAR_OUT = s_reg.wdt_clr;
  assign COUNTER_LATCH_HIGH_OUT = s_reg.latch_high;
  assign WORKING_REGISTER_OUT = s_reg.working_register;
  assign ARITH_STATUS_REGISTER_OUT = s_reg.status;

  // the decoded word is live only in its own execute phase
  logic exec_q3;
  assign exec_q3 = (s_reg.phase == BCCE_Q3) && !s_reg.forced_nop;

  default clocking bcce_cb @(posedge MCLK_IN);
  endclocking
  default disable iff (RST_IN);

  // ir reloads at the Q4 edge, so later checks look back two cycles
  bit_inv_one_a: assert property (
    exec_q3 && is_bitinv
    |=> $countones(s_reg.result ^ $past(s_reg.opnd)) == 1)
    else $error("bit toggle changed other than one bit");

  bit_inv_pos_a: assert property (
    exec_q3 && is_bitinv
    |=> s_reg.result[$past(op[10:8])] != $past(s_reg.opnd[op[10:8]]))
    else $error("bit toggle hit the wrong bit");

  bit_inv_flag_a: assert property (
    exec_q3 && is_bitinv |=> $stable(s_reg.status))
    else $error("bit toggle changed status");

  bit_inv_wr_a: assert property (
    exec_q3 && is_bitinv
    |=> ##1 MEM_WE_OUT && MEM_WDATA_OUT == $past(s_reg.result)
    && MEM_ADDR_OUT == $past(op[7:0], 2))
    else $error("bit toggle write wrong");

  call_target_a: assert property (
    exec_q3 && is_call
    |=> s_reg.pc == {$past(s_reg.pc[15:13]), $past(op[12:0])})
    else $error("call target wrong");

  call_push_a: assert property (
    exec_q3 && is_call
    |=> STACK_PUSH_OUT && STACK_DATA_OUT == $past(s_reg.pc))
    else $error("call return address wrong");

  push_only_a: assert property (
    STACK_PUSH_OUT |-> $past(exec_q3 && is_call))
    else $error("stack push without a call");

  call_latch_a: assert property (
    exec_q3 && is_call
    |=> s_reg.latch_high == {$past(s_reg.pc[15:13]), $past(op[12:8])})
    else $error("counter latch high wrong");

  call_page_a: assert property (
    exec_q3 && is_call
    |=> s_reg.pc[15:13] == $past(s_reg.pc[15:13]))
    else $error("call left its page");

  call_nop_a: assert property (
    exec_q3 && is_call |=> ##1 s_reg.forced_nop)
    else $error("call not followed by forced nop");

  call_hold_a: assert property (
    exec_q3 && is_call |=> ##1 $stable(s_reg.pc))
    else $error("counter stepped past the call target");

  zero_reg_a: assert property (
    exec_q3 && is_zero |=> ##1 MEM_WE_OUT && MEM_WDATA_OUT == 8'h00)
    else $error("clear did not zero the register");

  zero_work_a: assert property (
    exec_q3 && is_zero
    |=> ##1 w == ($past(op[8], 2) ? $past(w, 2) : 8'h00))
    else $error("clear handled working register wrong");

  wdt_pulse_a: assert property (
    exec_q3 && is_wdt |=> WDT_CLEAR_OUT)
    else $error("watchdog clear not issued");

  wdt_only_a: assert property (
    WDT_CLEAR_OUT |-> $past(exec_q3 && is_wdt))
    else $error("watchdog clear without its opcode");

  wdt_status_a: assert property (
    WDT_CLEAR_OUT |-> s_reg.status[`BCCE_ST_TO_BIT]
    && s_reg.status[`BCCE_ST_PD_BIT])
    else $error("watchdog clear left status bits low");

  comp_work_a: assert property (
    exec_q3 && is_comp
    |=> ##1 ($past(op[8], 2) || w == ~$past(s_reg.opnd, 2)))
    else $error("complement to working register wrong");

  comp_reg_a: assert property (
    exec_q3 && is_comp && op[8]
    |=> ##1 MEM_WE_OUT && MEM_WDATA_OUT == ~$past(s_reg.opnd, 2))
    else $error("complement to register wrong");

  comp_zero_a: assert property (
    exec_q3 && is_comp
    |=> s_reg.status[`BCCE_ST_Z_BIT] == ($past(s_reg.opnd) == 8'hFF))
    else $error("complement zero flag wrong");

  skip_eq_a: assert property (
    exec_q3 && is_skeq
    |=> ##1 s_reg.forced_nop == ($past(s_reg.opnd, 2) == $past(w, 2)))
    else $error("equal compare skip wrong");

  skip_eq_flag_a: assert property (
    exec_q3 && is_skeq |=> $stable(s_reg.status))
    else $error("equal compare changed status");

  skip_gt_a: assert property (
    exec_q3 && is_skgt
    |=> ##1 s_reg.forced_nop == ($past(s_reg.opnd, 2) > $past(w, 2)))
    else $error("greater compare skip wrong");

  // a compare must leave both the register file and working untouched
  cmp_no_store_a: assert property (
    exec_q3 && (is_skeq || is_skgt)
    |=> ##1 !MEM_WE_OUT && $stable(w))
    else $error("compare stored its difference");

  skip_step_a: assert property (
    exec_q3 && (is_skeq || is_skgt)
    |=> ##1 s_reg.pc == $past(s_reg.pc) + 16'h0001)
    else $error("counter did not step after a compare");

  nop_quiet_a: assert property (
    s_reg.phase == BCCE_Q3 && s_reg.forced_nop
    |=> !s_reg.res_to_reg && !s_reg.res_to_w && !STACK_PUSH_OUT
    && !WDT_CLEAR_OUT)
    else $error("forced nop had an effect");

  nop_once_a: assert property (
    s_reg.phase == BCCE_Q4 && s_reg.forced_nop |=> !s_reg.forced_nop)
    else $error("forced nop ran twice");

  fetch_pulse_a: assert property (
    s_reg.phase == BCCE_Q4 |=> INSTR_FETCH_OUT)
    else $error("no fetch after phase four");

  addr_low_a: assert property (
    s_reg.phase == BCCE_Q1 |=> MEM_ADDR_OUT == $past(op[7:0]))
    else $error("register address not the low byte");

endmodule // bcce_core
`default_nettype wire

// ### core/bcce_defines.svh
`ifndef BCCE_DEFINES_SVH
`define BCCE_DEFINES_SVH
// opcode patterns
`define BCCE_OP_BITINV 5'h07
`define BCCE_OP_CALL 3'h7
`define BCCE_OP_ZERO 7'h14
`define BCCE_OP_WDTCLR 16'h0004
`define BCCE_OP_COMP 7'h09
`define BCCE_OP_SKEQ 8'h31
`define BCCE_OP_SKGT 8'h32
// status bit positions in the arithmetic status register
`define BCCE_ST_TO_BIT 3
`define BCCE_ST_PD_BIT 2
`define BCCE_ST_Z_BIT 1
// reset values
`define BCCE_STATUS_RST 8'h0C
`define BCCE_PC_RST 16'h0000
`define BCCE_WORKING_REGISTER_RST 8'h00
`define BCCE_LATCH_RST 8'h00
// phases per instruction cycle
`define BCCE_PHASES 4
`endif

// ### core/bcce_pkg.sv
package bcce_pkg;
  typedef enum logic [1:0] {
    BCCE_Q1,
    BCCE_Q2,
    BCCE_Q3,
    BCCE_Q4
  } bcce_phase_type;

  typedef struct packed {
    logic we;
    logic [7:0] addr;
    logic [7:0] wdata;
  } bcce_mem_wr_type;

  typedef struct packed {
    logic push;
    logic [15:0] addr;
  } bcce_stack_push_type;

  typedef struct packed {
    bcce_phase_type phase;
    logic [15:0] ir;
    logic forced_nop;
    logic skip_pend;
    logic [15:0] pc;
    logic [7:0] latch_high;
    logic [7:0] working_register;
    logic [7:0] status;
    logic [7:0] opnd;
    logic [7:0] result;
    logic res_to_reg;
    logic res_to_w;
    bcce_mem_wr_type mem_wr;
    bcce_stack_push_type push;
    logic wdt_clr;
    logic fetch;
  } bcce_state_type;
endpackage

// ### testbench/bit_call_clear_compare_exec_bench.sv
`timescale 1ns/1ps
`default_nettype none
module bit_call_clear_compare_exec_bench;
  logic mclk;
  logic rst;
  logic [15:0] instr;
  logic [7:0] mem [256];
  logic [7:0] addr;
  logic [7:0] wdata;
  logic [7:0] latch;
  logic [7:0] working_register;
  logic [7:0] st;
  logic [15:0] pc;
  logic [15:0] push_data;
  logic [15:0] last_push;
  logic fetch;
  logic we;
  logic push;
  logic wdt_clr;
  int n_fail = 0;
  int checks = 0;
  int cyc = 0;
  int n_wdt = 0;
  int n_fetch = 0;
  // rows: word, working_register after, mem[word low byte] after, status, pc (FFFF: none)
  logic [55:0] rows [22] = '{
    56'h3C10_00_00_0C_FFFF, 56'h3F22_00_A2_0C_FFFF,
    56'h1233_CC_33_0C_FFFF, 56'h13FF_CC_00_0E_FFFF,
    56'h2940_CC_00_0E_FFFF, 56'h31CC_CC_CC_0E_FFFF,
    56'h1201_CC_01_0E_FFFF, 56'h32CB_CC_CB_0E_FFFF,
    56'h1201_FE_01_0C_FFFF, 56'h32FE_FE_FE_0C_FFFF,
    56'h1202_FD_02_0C_FFFF, 56'h32FE_FD_FE_0C_FFFF,
    56'h1203_FD_03_0C_FFFF, 56'h31FC_FD_FC_0C_FFFF,
    56'h1204_FB_04_0C_FFFF, 56'h2850_00_00_0C_FFFF,
    56'h0004_00_04_0C_FFFF, 56'hF234_00_34_0C_1234,
    56'h1201_00_01_0C_FFFF, 56'hEABC_00_BC_0C_0ABC,
    56'h1201_00_01_0C_FFFF, 56'h1205_FA_05_0C_FFFF
  };
  // read path is combinational so the operand settles well before sampling
  wire logic [7:0] rdata = mem[addr];

  bcce_core u_bcce_core (
    .MCLK_IN(mclk), .RST_IN(rst), .INSTR_IN(instr), .MEM_RDATA_IN(rdata),
    .PC_OUT(pc), .INSTR_FETCH_OUT(fetch), .MEM_ADDR_OUT(addr),
    .MEM_WE_OUT(we), .MEM_WDATA_OUT(wdata), .STACK_PUSH_OUT(push),
    .STACK_DATA_OUT(push_data), .WDT_CLEAR_OUT(wdt_clr),
    .COUNTER_LATCH_HIGH_OUT(latch), .WORKING_REGISTER_OUT(working_register),
    .ARITH_STATUS_REGISTER_OUT(st)
  );

  task automatic print_verdict();
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    checks++;
    if (g !== e) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask

  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end

  initial begin
    for (int i = 0; i < 256; i++) begin
      mem[i] = i[7:0];
    end
  end

  // data memory and pulse catchers; a hang ends the run here
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (we) begin
      mem[addr] <= wdata;
    end
    if (push) begin
      last_push <= push_data;
    end
    if (wdt_clr) begin
      n_wdt <= n_wdt + 1;
    end
    if (fetch) begin
      n_fetch <= n_fetch + 1;
    end
    if (cyc == 300) begin
      n_fail++;
      print_verdict();
    end
  end

  initial begin
    rst = 1'b1;
    instr = 16'h0000;
    last_push = 16'h0000;
    repeat (3) @(posedge mclk);
    #1;
    chk("working_register", 16'h0000, {8'h00, working_register});
    chk("status", 16'h000C, {8'h00, st});
    chk("pc", 16'h0000, pc);
    @(posedge mclk);
    rst <= 1'b0;
    // one word per instruction cycle; row k-2 has settled by mid-cycle k
    for (int k = 0; k < 24; k++) begin
      instr <= (k < 22) ? rows[k][55:40] : 16'h0000;
      repeat (2) @(posedge mclk);
      #1;
      if (k >= 2) begin
        chk("working_register", {8'h00, rows[k-2][39:32]}, {8'h00, working_register});
        chk("mem", {8'h00, rows[k-2][31:24]}, {8'h00, mem[rows[k-2][47:40]]});
        chk("status", {8'h00, rows[k-2][23:16]}, {8'h00, st});
        if (rows[k-2][15:0] != 16'hFFFF) begin
          chk("pc", rows[k-2][15:0], pc);
        end
      end
      repeat (2) @(posedge mclk);
    end
    #1;
    chk("push", 16'h1235, last_push);
    chk("latch", 16'h000A, {8'h00, latch});
    chk("wdt", 16'h0001, n_wdt[15:0]);
    chk("fetch", 16'h0017, n_fetch[15:0]);
    // reset in mid-run, then one word through the fresh pipeline
    @(posedge mclk);
    rst <= 1'b1;
    repeat (2) @(posedge mclk);
    #1;
    chk("working_register", 16'h0000, {8'h00, working_register});
    chk("latch", 16'h0000, {8'h00, latch});
    chk("pc", 16'h0000, pc);
    @(posedge mclk);
    rst <= 1'b0;
    instr <= 16'h1201;
    repeat (5) @(posedge mclk);
    #1;
    chk("pc", 16'h0001, pc);
    repeat (4) @(posedge mclk);
    #1;
    chk("working_register", 16'h00FE, {8'h00, working_register});
    print_verdict();
  end
endmodule // bit_call_clear_compare_exec_bench
`default_nettype wire
